// ==== hw/ebp_pkg.sv ====
`default_nettype none
package ebp_pkg;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFS_SYSCFG = 8'h00;
  localparam logic [7:0] OFS_ACC_ADDR = 8'h04;
  localparam logic [7:0] OFS_ACC_WDATA = 8'h08;
  localparam logic [7:0] OFS_ACC_CMD = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_DP_OUT = 8'h14;
  localparam logic [7:0] OFS_DP_DIR = 8'h18;
  localparam logic [7:0] OFS_AP_OUT = 8'h1c;
  localparam logic [7:0] OFS_AP_DIR = 8'h20;
  localparam logic [7:0] OFS_PIN_IN = 8'h24;

  // ==========================================================
  // Field positions of system_config_reg
  localparam int CFG_BUS_EN = 0;
  localparam int CFG_MUX = 1;
  localparam int CFG_WIDE = 2;
  localparam int CFG_WRITE_STROBE_CFG = 3;
  localparam int CFG_SPACE_LSB = 4;
  localparam int CFG_CS_LSB = 6;
  localparam int CFG_W = 10;

  // Field positions of the access command register
  localparam int CMD_WRITE = 0;
  localparam int CMD_BYTE = 1;
  localparam int CMD_HIGH = 2;
  localparam int CMD_CS_EN = 3;
  localparam int CMD_CS_LSB = 4;
  localparam int CMD_W = 6;

  // Field positions of the status register
  localparam int STS_BUSY = 0;
  localparam int STS_EXT_FETCH = 1;
  localparam int STS_STRAP_VALID = 2;
  localparam int STS_RDATA_LSB = 16;

  // ==========================================================
  // Reset values
  localparam logic [CFG_W-1:0] SYSCFG_RST = 10'h002;
  localparam logic [15:0] PORT_OUT_RST = 16'h0000;
  localparam logic [15:0] PORT_DIR_RST = 16'h0000;

  // ==========================================================
  // Bus cycle phase lengths and strap settle count in core_clk cycles
  localparam logic [3:0] ALE_CYCLES = 4'h2;
  localparam logic [3:0] HOLD_CYCLES = 4'h1;
  localparam logic [3:0] STROBE_CYCLES = 4'h6;
  localparam logic [3:0] RECOVER_CYCLES = 4'h1;
  localparam logic [1:0] STRAP_SETTLE = 2'h3;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // Bus cycle states
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_ALE = 5'b00010,
    ST_HOLD = 5'b00100,
    ST_STROBE = 5'b01000,
    ST_RECOVER = 5'b10000
  } ebp_state_t;

endpackage
`default_nettype wire

// ==== hw/ebp_top.sv ====
// Chosen here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none

module ebp_top import ebp_pkg::*; #(
  parameter int NUM_CS = 4,
  parameter bit DEMUX_EN = 1'b1
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // AXI4-Lite write channels
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Boot strap pin
  input wire logic external_access_sel_n,
  output logic fetch_external,
  output logic strap_valid,
  // Data port pins
  input wire logic [15:0] data_port_i,
  output logic [15:0] data_port_o,
  output logic [15:0] data_port_oe,
  // Address port pins
  input wire logic [15:0] address_port_i,
  output logic [15:0] address_port_o,
  output logic [15:0] address_port_oe,
  // Segment address lines
  output logic [5:0] seg_addr_o,
  output logic [5:0] seg_addr_oe,
  // Bus strobes and chip selects
  output logic addr_latch_en,
  output logic read_strobe_n,
  output logic low_byte_write_strobe_n,
  output logic [3:0] chip_select_out_n
);

  // ==========================================================
  // Declarations
  logic [CFG_W-1:0] system_config_reg;
  logic [21:0] acc_addr;
  logic [15:0] acc_wdata;
  logic [CMD_W-1:0] acc_cmd;
  logic [15:0] acc_rdata;
  logic [15:0] dp_out, dp_dir, ap_out, ap_dir;
  logic start_req, demux_seen;
  ebp_state_t state;
  logic [3:0] phase_cnt;
  logic [15:0] dp_s1, dp_s2, dp_s3, dp_filt;
  logic [15:0] ap_s1, ap_s2, ap_s3, ap_filt;
  logic ea_s1, ea_s2, ea_s3;
  logic [1:0] strap_cnt;
  logic aw_hold, w_hold;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic do_write;
  logic [31:0] rd_mux;
  logic rd_ok, wr_ok;
  logic bus_en, eff_mux, wide, low_mode, acc_write, low_incl;
  logic [1:0] acc_cs;
  logic [5:0] seg_mask;
  logic in_cycle, addr_ph, strobe_ph;
  logic [7:0] wbyte;
  logic [15:0] next_dp_o, next_dp_oe, next_ap_o, next_ap_oe;
  logic [5:0] next_seg_o, next_seg_oe;
  logic next_ale, next_rd_n, next_wr_n;
  logic [3:0] next_cs_n;

  // Byte-lane merge for partial AXI writes
  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return res;
  endfunction

  // Address decode shared by both directions
  function automatic logic addr_mapped(input logic [7:0] a);
    return (a == OFS_SYSCFG) || (a == OFS_ACC_ADDR) ||
           (a == OFS_ACC_WDATA) || (a == OFS_ACC_CMD) ||
           (a == OFS_STATUS) || (a == OFS_DP_OUT) ||
           (a == OFS_DP_DIR) || (a == OFS_AP_OUT) ||
           (a == OFS_AP_DIR) || (a == OFS_PIN_IN);
  endfunction

  // ==========================================================
  // Configuration decode
  // mode bit select
  assign low_mode = system_config_reg[CFG_WRITE_STROBE_CFG];
  assign eff_mux = system_config_reg[CFG_MUX] | ~DEMUX_EN;
  assign bus_en = system_config_reg[CFG_BUS_EN];
  assign wide = system_config_reg[CFG_WIDE];
  assign acc_write = acc_cmd[CMD_WRITE];
  assign acc_cs = acc_cmd[CMD_CS_LSB +: 2];
  assign low_incl = ~acc_cmd[CMD_BYTE] | ~acc_cmd[CMD_HIGH];
  assign wbyte = (acc_cmd[CMD_BYTE] & acc_cmd[CMD_HIGH]) ?
                 acc_wdata[15:8] : acc_wdata[7:0];
  assign in_cycle = (state != ST_IDLE);
  assign addr_ph = (state == ST_ALE) || (state == ST_HOLD);
  assign strobe_ph = (state == ST_STROBE);

  always_comb begin
    unique case (system_config_reg[CFG_SPACE_LSB +: 2])
      2'h0: seg_mask = 6'h00;
      2'h1: seg_mask = 6'h03;
      2'h2: seg_mask = 6'h0f;
      2'h3: seg_mask = 6'h3f;
    endcase
  end

  // ==========================================================
  // Pin synchronisers; a change counts once stages two and three agree
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      {dp_s1, dp_s2, dp_s3, dp_filt} <= {4{16'h0000}};
      {ap_s1, ap_s2, ap_s3, ap_filt} <= {4{16'h0000}};
      {ea_s1, ea_s2, ea_s3} <= 3'h7;
    end else begin
      dp_s1 <= data_port_i;
      dp_s2 <= dp_s1;
      dp_s3 <= dp_s2;
      dp_filt <= (dp_s2 & ~(dp_s2 ^ dp_s3)) | (dp_filt & (dp_s2 ^ dp_s3));
      ap_s1 <= address_port_i;
      ap_s2 <= ap_s1;
      ap_s3 <= ap_s2;
      ap_filt <= (ap_s2 & ~(ap_s2 ^ ap_s3)) | (ap_filt & (ap_s2 ^ ap_s3));
      ea_s1 <= external_access_sel_n;
      ea_s2 <= ea_s1;
      ea_s3 <= ea_s2;
    end
  end

  // Strap is caught once the chain has refilled after reset release
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      strap_cnt <= 2'h0;
      strap_valid <= 1'b0;
      fetch_external <= 1'b0;
    end else if (!strap_valid) begin
      if (strap_cnt != STRAP_SETTLE) begin
        strap_cnt <= strap_cnt + 2'h1;
      end else if (ea_s2 == ea_s3) begin
        fetch_external <= ~ea_s3;
        strap_valid <= 1'b1;
      end
    end
  end

  // ==========================================================
  // AXI4-Lite handshakes; address and data may arrive in either order
  assign do_write = aw_hold & w_hold & ~s_axi_bvalid;
  assign wr_ok = addr_mapped(aw_addr_q);
  assign rd_ok = addr_mapped(s_axi_araddr);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (!aw_hold && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (!w_hold && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
      if (do_write) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read data is sampled at the address handshake
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (s_axi_araddr)
      OFS_SYSCFG: rd_mux[CFG_W-1:0] = system_config_reg;
      OFS_ACC_ADDR: rd_mux[21:0] = acc_addr;
      OFS_ACC_WDATA: rd_mux[15:0] = acc_wdata;
      OFS_ACC_CMD: rd_mux[CMD_W-1:0] = acc_cmd;
      OFS_STATUS: begin
        rd_mux[STS_BUSY] = in_cycle | start_req;
        rd_mux[STS_EXT_FETCH] = fetch_external;
        rd_mux[STS_STRAP_VALID] = strap_valid;
        rd_mux[STS_RDATA_LSB +: 16] = acc_rdata;
      end
      OFS_DP_OUT: rd_mux[15:0] = dp_out;
      OFS_DP_DIR: rd_mux[15:0] = dp_dir;
      OFS_AP_OUT: rd_mux[15:0] = ap_out;
      OFS_AP_DIR: rd_mux[15:0] = ap_dir;
      OFS_PIN_IN: rd_mux = {ap_filt, dp_filt};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  // ==========================================================
  // Register file; access registers are frozen while a cycle runs
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      system_config_reg <= SYSCFG_RST;
      acc_addr <= 22'h000000;
      acc_wdata <= 16'h0000;
      acc_cmd <= '0;
      dp_out <= PORT_OUT_RST;
      dp_dir <= PORT_DIR_RST;
      ap_out <= PORT_OUT_RST;
      ap_dir <= PORT_DIR_RST;
      start_req <= 1'b0;
    end else begin
      start_req <= 1'b0;
      if (do_write && !in_cycle && !start_req) begin
        unique case (aw_addr_q)
          OFS_SYSCFG: system_config_reg <= CFG_W'(wmerge(
              {22'h0, system_config_reg}, w_data_q, w_strb_q));
          OFS_ACC_ADDR: acc_addr <= 22'(wmerge({10'h0, acc_addr},
              w_data_q, w_strb_q));
          OFS_ACC_WDATA: acc_wdata <= 16'(wmerge({16'h0, acc_wdata},
              w_data_q, w_strb_q));
          OFS_ACC_CMD: begin
            // Writing the command starts a cycle when the bus is on
            acc_cmd <= w_data_q[CMD_W-1:0];
            start_req <= bus_en;
          end
          OFS_DP_OUT: dp_out <= 16'(wmerge({16'h0, dp_out},
              w_data_q, w_strb_q));
          OFS_DP_DIR: dp_dir <= 16'(wmerge({16'h0, dp_dir},
              w_data_q, w_strb_q));
          OFS_AP_OUT: ap_out <= 16'(wmerge({16'h0, ap_out},
              w_data_q, w_strb_q));
          OFS_AP_DIR: ap_dir <= 16'(wmerge({16'h0, ap_dir},
              w_data_q, w_strb_q));
          default: start_req <= 1'b0;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      demux_seen <= 1'b0;
    end else if (bus_en && !eff_mux) begin
      demux_seen <= 1'b1;
    end
  end

  // ==========================================================
  // Bus cycle sequencer
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      phase_cnt <= 4'h0;
      acc_rdata <= 16'h0000;
    end else begin
      if (phase_cnt != 4'h0) begin
        phase_cnt <= phase_cnt - 4'h1;
      end
      unique case (state)
        ST_IDLE: if (start_req) begin
          state <= ST_ALE;
          phase_cnt <= ALE_CYCLES - 4'h1;
        end
        ST_ALE: if (phase_cnt == 4'h0) begin
          state <= ST_HOLD;
          phase_cnt <= HOLD_CYCLES - 4'h1;
        end
        ST_HOLD: if (phase_cnt == 4'h0) begin
          state <= ST_STROBE;
          phase_cnt <= STROBE_CYCLES - 4'h1;
        end
        ST_STROBE: if (phase_cnt == 4'h0) begin
          state <= ST_RECOVER;
          phase_cnt <= RECOVER_CYCLES - 4'h1;
        end
        ST_RECOVER: if (phase_cnt == 4'h0) begin
          state <= ST_IDLE;
          // Sampled as the strobe ends, so the four-stage pin filter
          // still lets a memory answer in its second strobe cycle
          if (!acc_write) begin
            acc_rdata <= wide ? dp_filt : {8'h00, dp_filt[7:0]};
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Next pin values; unclaimed pins fall back to GPIO, but multiplexed mode releases the whole data port
  always_comb begin
    next_dp_o = dp_out;
    next_dp_oe = dp_dir;
    next_ap_o = ap_out;
    next_ap_oe = ap_dir;
    next_seg_o = 6'h00;
    next_seg_oe = 6'h00;
    next_ale = 1'b0;
    next_rd_n = 1'b1;
    next_wr_n = 1'b1;
    next_cs_n = 4'hf;
    if (bus_en) begin
      next_seg_o = acc_addr[21:16] & seg_mask;
      next_seg_oe = seg_mask;
      next_ale = (state == ST_ALE) & eff_mux;
      next_rd_n = ~(strobe_ph & ~acc_write);
      next_wr_n = ~(strobe_ph & acc_write & (~low_mode | ~wide | low_incl));
      if (eff_mux) begin
        next_dp_oe = 16'h0000;
        if (addr_ph) begin
          next_dp_o = acc_addr[15:0];
          next_dp_oe = 16'hffff;
        end
        if (in_cycle && !wide) begin
          next_dp_o[15:8] = acc_addr[15:8];
          next_dp_oe[15:8] = 8'hff;
        end
        if (strobe_ph && acc_write) begin
          next_dp_o[7:0] = wide ? acc_wdata[7:0] : wbyte;
          next_dp_oe[7:0] = 8'hff;
          if (wide) begin
            next_dp_o[15:8] = acc_wdata[15:8];
            next_dp_oe[15:8] = 8'hff;
          end
        end
      end else begin
        next_dp_oe[7:0] = 8'h00;
        if (wide) begin
          next_dp_oe[15:8] = 8'h00;
        end
        if (strobe_ph && acc_write) begin
          next_dp_o[7:0] = wide ? acc_wdata[7:0] : wbyte;
          next_dp_oe[7:0] = 8'hff;
          if (wide) begin
            next_dp_o[15:8] = acc_wdata[15:8];
            next_dp_oe[15:8] = 8'hff;
          end
        end
      end
      if (demux_seen) begin
        next_ap_o = acc_addr[15:0];
        next_ap_oe = 16'hffff;
      end
      if (in_cycle && acc_cmd[CMD_CS_EN] && (32'(acc_cs) < NUM_CS) &&
          system_config_reg[CFG_CS_LSB + 32'(acc_cs)]) begin
        next_cs_n[acc_cs] = 1'b0;
      end
    end
  end

  // All pins leave from flip-flops
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      data_port_o <= 16'h0000;
      data_port_oe <= 16'h0000;
      address_port_o <= 16'h0000;
      address_port_oe <= 16'h0000;
      seg_addr_o <= 6'h00;
      seg_addr_oe <= 6'h00;
      addr_latch_en <= 1'b0;
      read_strobe_n <= 1'b1;
      low_byte_write_strobe_n <= 1'b1;
      chip_select_out_n <= 4'hf;
    end else begin
      data_port_o <= next_dp_o;
      data_port_oe <= next_dp_oe;
      address_port_o <= next_ap_o;
      address_port_oe <= next_ap_oe;
      seg_addr_o <= next_seg_o;
      seg_addr_oe <= next_seg_oe;
      addr_latch_en <= next_ale;
      read_strobe_n <= next_rd_n;
      low_byte_write_strobe_n <= next_wr_n;
      chip_select_out_n <= next_cs_n;
    end
  end

endmodule
`default_nettype wire

// ==== bench/ebp_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module ebp_checker (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Register bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // Strap and pins
  input wire logic fetch_external,
  input wire logic strap_valid,
  input wire logic [15:0] data_port_o,
  input wire logic [15:0] data_port_oe,
  input wire logic addr_latch_en,
  input wire logic read_strobe_n,
  input wire logic low_byte_write_strobe_n
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  // ==========================================================
  // Register bus answers come a fixed cycle after the handshake
  axi_bresp_a: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
    else $error("write response missing");
  axi_bhold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  axi_rresp_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid)
    else $error("read response missing");

  // ==========================================================
  // Strobe shapes and pin ownership during bus cycles
  read_len_a: assert property (
    $fell(read_strobe_n) |-> (!read_strobe_n)[*6] ##1 read_strobe_n)
    else $error("read strobe length wrong");
  write_len_a: assert property (
    $fell(low_byte_write_strobe_n) |->
    (!low_byte_write_strobe_n)[*6] ##1 low_byte_write_strobe_n)
    else $error("write strobe length wrong");
  strobe_excl_a: assert property (
    !read_strobe_n |-> low_byte_write_strobe_n && !addr_latch_en)
    else $error("strobes overlap");
  ale_len_a: assert property (
    $rose(addr_latch_en) |-> addr_latch_en[*2] ##1 !addr_latch_en)
    else $error("latch strobe length wrong");
  ale_addr_a: assert property (
    $fell(addr_latch_en) |-> data_port_oe[7:0] == 8'hff &&
    $stable(data_port_o[7:0]))
    else $error("address gone at latch fall");
  read_release_a: assert property (
    !read_strobe_n |-> data_port_oe[7:0] == 8'h00)
    else $error("data lanes driven in read");
  strap_hold_a: assert property (
    !$rose(strap_valid) |-> $stable(fetch_external) &&
    (strap_valid || !fetch_external))
    else $error("fetch select changed");
endmodule

bind ebp_top ebp_checker chk (.*);
`default_nettype wire

// ==== bench/ebp_ext_mem.sv ====
`timescale 1ns/1ps
`default_nettype none
module ebp_ext_mem (
  // Clock
  input wire logic core_clk,
  // Bus pins seen by the memory
  input wire logic ale,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [15:0] dp_o,
  input wire logic [15:0] dp_oe,
  input wire logic [15:0] ap_o,
  input wire logic [15:0] ap_oe,
  // Strobe cycles before read data is valid
  input wire logic [1:0] lat,
  output logic [15:0] dp_drv
);
  logic [15:0] mem [0:255];
  logic [15:0] lat_addr = 16'h0;
  logic [15:0] last = 16'h0;
  logic [2:0] age = 3'h0;
  logic [15:0] addr;
  logic ready;

  // Demux address port wins; else the latched shared address
  assign addr = (ap_oe == 16'hffff) ? ap_o : lat_addr;
  assign ready = !rd_n && age >= {1'h0, lat};

  // answer every read strobe, promptly or slowly
  always @(posedge core_clk) begin
    if (ale)
      lat_addr <= dp_o;
    if (!wr_n)
      mem[addr[8:1]] <= (mem[addr[8:1]] & ~dp_oe) | (dp_o & dp_oe);
    age <= rd_n ? 3'h0 : age + 3'h1;
    if (ready)
      last <= mem[addr[8:1]];
  end

  // Released lines show the inverse, so stale data never matches
  assign dp_drv = ready ? mem[addr[8:1]] : ~last;
endmodule
`default_nettype wire

// ==== bench/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ebp_pkg::*;
  // ==========================================================
  // Stimulus, pin levels and bench state
  logic core_clk = 1'h0;
  logic rst = 1'h1;
  logic [7:0] s_axi_awaddr = 8'h0;
  logic [7:0] s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'h0;
  logic s_axi_wvalid = 1'h0;
  logic s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0;
  logic s_axi_rready = 1'h0;
  logic external_access_sel_n = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, fetch_external, strap_valid, addr_latch_en;
  logic read_strobe_n, low_byte_write_strobe_n;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, rd, st;
  logic [15:0] data_port_o, data_port_oe, address_port_o, address_port_oe;
  logic [15:0] mem_drv, s_dp, s_oe, s_ap, s_apoe;
  logic [15:0] ext_val = 16'h0;
  logic ext_en = 1'h0;
  logic [1:0] lat = 2'h0;
  logic [1:0] er = 2'h0;
  logic [5:0] seg_addr_o, seg_addr_oe, s_seg, s_sego;
  logic [3:0] chip_select_out_n, s_cs;
  int err_count = 0;
  int check_count = 0;
  int cyc = 0;
  int wr_cnt = 0;
  int ale_cnt = 0;
  // Undriven address lines read back inverted; undriven data lines take the memory or ext_val
  wire logic [15:0] data_port_i = (data_port_oe & data_port_o) |
    (~data_port_oe & (ext_en ? ext_val : mem_drv));
  wire logic [15:0] address_port_i = (address_port_oe & address_port_o) |
    (~address_port_oe & ~address_port_o);

  ebp_top dut (.*);
  ebp_ext_mem mem (.core_clk(core_clk), .ale(addr_latch_en),
    .rd_n(read_strobe_n), .wr_n(low_byte_write_strobe_n),
    .dp_o(data_port_o), .dp_oe(data_port_oe), .ap_o(address_port_o),
    .ap_oe(address_port_oe), .lat(lat), .dp_drv(mem_drv));

  // Clock
  always #25 core_clk = ~core_clk;

  // Pin snapshot during strobes, pulse counters and hang limit
  always @(posedge core_clk) begin
    if (!read_strobe_n || !low_byte_write_strobe_n) begin
      s_dp <= data_port_o;
      s_oe <= data_port_oe;
      s_ap <= address_port_o;
      s_apoe <= address_port_oe;
      s_seg <= seg_addr_o;
      s_sego <= seg_addr_oe;
      s_cs <= chip_select_out_n;
    end
    if ($fell(low_byte_write_strobe_n))
      wr_cnt <= wr_cnt + 1;
    if ($rose(addr_latch_en))
      ale_cnt <= ale_cnt + 1;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      give_verdict();
    end
  end

  // ==========================================================
  // Shared tasks
  task chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      err_count++;
      $display("wrong value at %0t: got %h exp %h", $time, s, e);
    end
  endtask

  // Waits have no limit of their own; a hang ends at the cycle ceiling
  task reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'h1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge core_clk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
    chk({30'h0, s_axi_bresp}, {30'h0, er});
  endtask

  task reg_rd(input logic [7:0] a);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge core_clk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    rd = s_axi_rdata;
    s_axi_rready <= 1'h0;
    chk({30'h0, s_axi_rresp}, {30'h0, er});
  endtask

  // One external bus cycle, waiting on the busy flag
  task op(input logic [21:0] a, input logic [15:0] d, input logic [5:0] c);
    reg_wr(OFS_ACC_ADDR, {10'h0, a});
    reg_wr(OFS_ACC_WDATA, {16'h0, d});
    reg_wr(OFS_ACC_CMD, {26'h0, c});
    do begin
      reg_rd(OFS_STATUS);
    end while (rd[0] !== 1'h0);
    st = rd;
  endtask

  task cfg(input logic [9:0] c);
    reg_wr(OFS_SYSCFG, {22'h0, c});
  endtask

  task do_reset(input logic sel);
    @(posedge core_clk);
    rst <= 1'h1;
    external_access_sel_n <= sel;
    repeat (2) @(posedge core_clk);
    rst <= 1'h0;
    repeat (10) @(posedge core_clk);
  endtask

  task wr_try(input logic [9:0] c, input logic [5:0] m, input int inc);
    int w0;
    cfg(c);
    w0 = wr_cnt;
    op(22'h12, 16'h1234, m);
    chk(wr_cnt - w0, inc);
  endtask

  // ==========================================================
  // Scenarios
  task t_reset;
    chk({addr_latch_en, read_strobe_n, low_byte_write_strobe_n}, 3'h3);
    chk({chip_select_out_n, data_port_oe}, 20'hf0000);
    reg_rd(OFS_SYSCFG);
    chk(rd, {22'h0, SYSCFG_RST});
  endtask

  task t_strap;
    do_reset(1'h1);
    chk(fetch_external, 1'h0);
    do_reset(1'h0);
    chk(fetch_external, 1'h1);
    reg_rd(OFS_STATUS);
    chk(rd[2:1], 2'h3);
  endtask

  task t_mux;
    int a0;
    cfg(10'h047);
    a0 = ale_cnt;
    wr_try(10'h047, 6'h09, 1);
    chk(ale_cnt - a0, 1);
    chk(mem.mem[9], 16'h1234);
    lat <= 2'h1;
    op(22'h12, 16'h0, 6'h08);
    lat <= 2'h0;
    chk(st[31:16], 16'h1234);
    chk(s_cs, 4'he);
    cfg(10'h043);
    op(22'h00a512, 16'h0, 6'h00);
    chk({s_dp[15:8], s_oe}, 24'ha5ff00);
  endtask

  task t_lowbyte;
    wr_try(10'h04f, 6'h07, 0);
    wr_try(10'h04f, 6'h03, 1);
    wr_try(10'h04f, 6'h01, 1);
    wr_try(10'h04b, 6'h07, 1);
    wr_try(10'h047, 6'h07, 1);
  endtask

  task t_demux;
    int a0;
    cfg(10'h035);
    a0 = ale_cnt;
    op(22'h2a1234, 16'h5678, 6'h01);
    chk(s_ap, 16'h1234);
    chk(s_seg, 6'h2a);
    chk(ale_cnt - a0, 0);
    chk(mem.mem[8'h1a], 16'h5678);
    reg_wr(OFS_DP_DIR, 32'hff00);
    reg_wr(OFS_DP_OUT, 32'ha500);
    cfg(10'h031);
    op(22'h000100, 16'h0033, 6'h01);
    chk({s_dp[15:8], s_oe[15:8]}, 16'ha5ff);
    cfg(10'h037);
    op(22'h004321, 16'h0, 6'h00);
    chk({s_ap, s_apoe}, 32'h4321ffff);
  endtask

  task t_space_cs;
    for (int i = 0; i < 4; i++) begin
      cfg(10'h3c7 | 10'(i << 4));
      op(22'h3f0012, 16'h0, 6'h08 | 6'(i << 4));
      chk(s_sego, 6'h3f >> (6 - 2 * i));
      chk(s_cs, {28'h0, ~(4'h1 << i)});
    end
  endtask

  task t_gpio;
    cfg(10'h002);
    reg_wr(OFS_DP_DIR, 32'h00f0);
    reg_wr(OFS_DP_OUT, 32'h1234);
    ext_en <= 1'h1;
    ext_val <= 16'habcd;
    repeat (8) @(posedge core_clk);
    chk(data_port_oe, 16'h00f0);
    chk(data_port_o[7:4], 4'h3);
    reg_rd(OFS_PIN_IN);
    chk(rd[15:0], 16'hab3d);
    ext_en <= 1'h0;
  endtask

  task t_unmapped;
    er = RESP_SLVERR;
    reg_wr(8'h28, 32'h5);
    reg_rd(8'h28);
    er = RESP_OKAY;
  endtask

  task give_verdict;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Main sequence; the strap pin starts low as the board must
  initial begin
    repeat (2) @(posedge core_clk);
    rst <= 1'h0;
    t_reset();
    t_strap();
    t_mux();
    t_lowbyte();
    t_demux();
    t_space_cs();
    t_gpio();
    t_unmapped();
    give_verdict();
  end
endmodule
`default_nettype wire
